/* File: amc_mode_regs.sv */
// Purpose: mode control register bank behind a three-wire serial port
// Assumes: sck, cs_n, sdi asynchronous to core_clk; sck slow against core_clk
// Notes:   sdo is open drain, pulled low only; sdo_oe_n low while pulling
// Functional notes
// - writing 1 to bit 7 at address 00h clears every mode register to 00h
// - the reset bit clears itself once the bank reset is done
// - address 00h is write only and holds no readable state
// - unassigned bits, incl. reset bits 6-0 and address 02h, read as 0
// - converter bit 3 selects front-end gain, 0 unity, 1 gain 1.5
// - converter bit 2 set turns dither off, clear leaves it on
// - converter bit 1 set powers the converter down
// - clock bit 5 set turns encode clock termination on
// - clock bit 4 set disables the keep-alive oscillator
// - clock bit 3 set inverts the forwarded output clock
// - clock bits 2-1 delay output clock by 0, 1/8, 1/4 or 3/8 period
// - clock bit 0 set enables the duty cycle stabilizer
// - output bits 6-4 select LVDS driver current, code 011 unused
// - output bit 3 turns on termination and doubles the driver current
// - output bit 2 set puts all digital outputs in high impedance
// - output bit 0 selects DDR LVDS when 0, full-rate CMOS when 1
// - each transfer is read flag, 7-bit address, 8 data bits
// - only the first 16 sck rising edges after cs_n low are taken
// - during a read the register keeps its value, sdi data ignored
`timescale 1ns/1ps
module amc_mode_regs (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        sdi,
    output logic             sdo_o,
    output logic             sdo_oe_n,
    output logic             transfer_active,
    output logic             front_end_gain_select,
    output logic             dither_disable,
    output logic             power_down_request,
    output logic             encode_term_en,
    output logic             keepalive_osc_disable,
    output logic             out_clock_invert,
    output logic [1:0]       out_clock_phase_delay,
    output logic             duty_cycle_stabilizer_en,
    output logic [2:0]       driver_current_select,
    output logic             internal_termination_en,
    output logic             output_disable,
    output logic             output_format_cmos,
    output amc_pkg::amc_cur_t lvds_current_units
);
    import amc_pkg::*;

    typedef struct packed {
        amc_phase_e  phase;
        logic [4:0]  bit_cnt;
        logic [14:0] shift;
        logic        rd;
        logic [7:0]  rd_data;
        logic        sdo_low;
        logic        sreset;
        logic [7:0]  conv;
        logic [7:0]  clkc;
        logic [7:0]  outm;
        amc_cur_t    cur;
        logic        sck_d;
    } amc_core_s;

    amc_core_s              st_ff;
    amc_core_s              nxt_st;
    logic [AMC_SYNC_W-1:0]  pins_s;
    logic                   cs_s;
    logic                   sck_s;
    logic                   sdi_s;
    logic                   sck_rise;
    logic                   sck_fall;
    logic [6:0]             wr_addr;
    logic [7:0]             wr_data;
    logic [6:0]             rd_addr;

    ////////////////////////////////////////////////////////////////////////////////
    // readback mux; address 00h, 02h and unmapped read zero
    function automatic logic [7:0] amc_read(input logic [6:0] addr,
                                            input logic [7:0] conv,
                                            input logic [7:0] clkc,
                                            input logic [7:0] outm);
        logic [7:0] val;
        val = AMC_RESET_VAL;
        case (addr)
            AMC_ADDR_CONV: val = conv;
            AMC_ADDR_CLK:  val = clkc;
            AMC_ADDR_OUTM: val = outm;
            default:       val = AMC_RESET_VAL;
        endcase
        return val;
    endfunction

    // driver current from select code and termination
    function automatic amc_cur_t amc_current(input logic [2:0] sel, input logic term);
        amc_cur_t base;
        base = AMC_CUR_NONE;
        case (sel)
            3'h0:    base = AMC_CUR_3P5;
            3'h1:    base = AMC_CUR_4P0;
            3'h2:    base = AMC_CUR_4P5;
            3'h3:    base = AMC_CUR_NONE;
            3'h4:    base = AMC_CUR_3P0;
            3'h5:    base = AMC_CUR_2P5;
            3'h6:    base = AMC_CUR_2P1;
            default: base = AMC_CUR_1P75;
        endcase
        if (term) begin
            base = {base[6:0], 1'b0};
        end
        return base;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, order {sdi, sck, cs_n}
    amc_sync u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in ({sdi, sck, cs_n}),
        .sync_out (pins_s)
    );

    // edge detection and word fields
    assign cs_s     = pins_s[0];
    assign sck_s    = pins_s[1];
    assign sdi_s    = pins_s[2];
    assign sck_rise = sck_s & ~st_ff.sck_d;
    assign sck_fall = ~sck_s & st_ff.sck_d;
    assign wr_addr  = st_ff.shift[13:7];
    assign wr_data  = {st_ff.shift[6:0], sdi_s};
    assign rd_addr  = {st_ff.shift[5:0], sdi_s};

    ////////////////////////////////////////////////////////////////////////////////
    // next state: serial framing, register writes, readback, soft reset
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sck_d = sck_s;
        // bank reset completes in one cycle, then the bit drops
        if (st_ff.sreset) begin
            nxt_st.conv   = AMC_RESET_VAL;
            nxt_st.clkc   = AMC_RESET_VAL;
            nxt_st.outm   = AMC_RESET_VAL;
            nxt_st.sreset = 1'b0;
        end
        if (cs_s) begin
            // chip select high ends or aborts a transfer
            nxt_st.phase   = PH_IDLE;
            nxt_st.bit_cnt = 5'h00;
            nxt_st.rd      = 1'b0;
            nxt_st.sdo_low = 1'b0;
        end else begin
            case (st_ff.phase)
                PH_IDLE: begin
                    nxt_st.phase   = PH_CMD;
                    nxt_st.bit_cnt = 5'h00;
                    nxt_st.rd      = 1'b0;
                end
                PH_CMD: begin
                    if (sck_rise) begin
                        nxt_st.shift   = {st_ff.shift[13:0], sdi_s};
                        nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
                        if (st_ff.bit_cnt == 5'h00) begin
                            nxt_st.rd = sdi_s;
                        end
                        if (st_ff.bit_cnt == AMC_CNT_ADDR) begin
                            nxt_st.phase   = PH_DATA;
                            nxt_st.rd_data = amc_read(rd_addr, st_ff.conv, st_ff.clkc,
                                                      st_ff.outm);
                        end
                    end
                end
                PH_DATA: begin
                    if (sck_rise) begin
                        nxt_st.shift   = {st_ff.shift[13:0], sdi_s};
                        nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
                        if (st_ff.bit_cnt == AMC_CNT_LAST) begin
                            nxt_st.phase = PH_DONE;
                            // reads never touch the bank
                            if (!st_ff.rd) begin
                                case (wr_addr)
                                    AMC_ADDR_RESET: begin
                                        if (wr_data[AMC_SRST_BIT]) begin
                                            nxt_st.sreset = 1'b1;
                                        end
                                    end
                                    AMC_ADDR_CONV: nxt_st.conv = wr_data & AMC_CONV_MASK;
                                    AMC_ADDR_CLK:  nxt_st.clkc = wr_data & AMC_CLK_MASK;
                                    AMC_ADDR_OUTM: nxt_st.outm = wr_data & AMC_OUTM_MASK;
                                    default:       nxt_st.sreset = st_ff.sreset;
                                endcase
                            end
                        end
                    end else if (sck_fall && st_ff.rd) begin
                        // open drain: pull low for a 0, release for a 1
                        nxt_st.sdo_low = ~st_ff.rd_data[7];
                        nxt_st.rd_data = {st_ff.rd_data[6:0], 1'b0};
                    end
                end
                PH_DONE: begin
                    // further edges are ignored; release sdo after the last bit
                    if (sck_fall) begin
                        nxt_st.sdo_low = 1'b0;
                    end
                end
                default: begin
                    nxt_st.phase = PH_IDLE;
                end
            endcase
        end
        nxt_st.cur = amc_current(st_ff.outm[AMC_CUR_LSB+:3], st_ff.outm[AMC_TERM_BIT]);
    end

    // state register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs from the register bank
    assign sdo_o                    = 1'b0;
    assign sdo_oe_n                 = ~st_ff.sdo_low;
    assign transfer_active          = (st_ff.phase != PH_IDLE);
    assign front_end_gain_select    = st_ff.conv[AMC_GAIN_BIT];
    assign dither_disable           = st_ff.conv[AMC_DITHER_BIT];
    assign power_down_request       = st_ff.conv[AMC_PDN_BIT];
    assign encode_term_en           = st_ff.clkc[AMC_ETERM_BIT];
    assign keepalive_osc_disable    = st_ff.clkc[AMC_KALIVE_BIT];
    assign out_clock_invert         = st_ff.clkc[AMC_CINV_BIT];
    assign out_clock_phase_delay    = st_ff.clkc[AMC_PHASE_LSB+:2];
    assign duty_cycle_stabilizer_en = st_ff.clkc[AMC_STAB_BIT];
    assign driver_current_select    = st_ff.outm[AMC_CUR_LSB+:3];
    assign internal_termination_en  = st_ff.outm[AMC_TERM_BIT];
    assign output_disable           = st_ff.outm[AMC_OUTDIS_BIT];
    assign output_format_cmos       = st_ff.outm[AMC_FMT_BIT];
    assign lvds_current_units       = st_ff.cur;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking amc_cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // last edge of a write transfer to a given address
    sequence wr_commit_s(logic [6:0] a);
        !cs_s && st_ff.phase == PH_DATA && sck_rise && !st_ff.rd
            && st_ff.bit_cnt == AMC_CNT_LAST && wr_addr == a;
    endsequence

    // falling edge while shifting readback data
    sequence rd_bit_s;
        !cs_s && st_ff.phase == PH_DATA && st_ff.rd && sck_fall && !sck_rise;
    endsequence

    // bank cleared one cycle after the reset bit, and the bit drops
    sreset_clear_a: assert property (
        st_ff.sreset |=> (st_ff.conv == AMC_RESET_VAL && st_ff.clkc == AMC_RESET_VAL
                          && st_ff.outm == AMC_RESET_VAL && !st_ff.sreset))
        else $error("soft reset did not clear the bank");

    // a reset write raises the bit for exactly one cycle
    sreset_pulse_a: assert property (
        wr_commit_s(AMC_ADDR_RESET) ##0 wr_data[AMC_SRST_BIT]
            |=> st_ff.sreset ##1 !st_ff.sreset)
        else $error("soft reset bit not a single pulse");

    // converter control write lands masked
    conv_write_a: assert property (
        wr_commit_s(AMC_ADDR_CONV) |=> st_ff.conv == ($past(wr_data) & AMC_CONV_MASK))
        else $error("converter control write lost");

    // clock control write lands masked
    clk_write_a: assert property (
        wr_commit_s(AMC_ADDR_CLK) |=> st_ff.clkc == ($past(wr_data) & AMC_CLK_MASK))
        else $error("clock control write lost");

    // output mode write lands masked
    outm_write_a: assert property (
        wr_commit_s(AMC_ADDR_OUTM) |=> st_ff.outm == ($past(wr_data) & AMC_OUTM_MASK))
        else $error("output mode write lost");

    // unassigned bits never hold a one
    unused_zero_a: assert property (
        ((st_ff.conv & ~AMC_CONV_MASK) == 8'h00) && ((st_ff.clkc & ~AMC_CLK_MASK) == 8'h00)
            && ((st_ff.outm & ~AMC_OUTM_MASK) == 8'h00))
        else $error("unassigned register bit set");

    // a read transfer leaves the bank alone
    read_hold_a: assert property (
        (st_ff.rd && !st_ff.sreset) |=> $stable(st_ff.conv) && $stable(st_ff.clkc)
                                        && $stable(st_ff.outm))
        else $error("register changed during a read");

    // address 00h reads back zero
    addr0_read_a: assert property (
        (!cs_s && st_ff.phase == PH_CMD && sck_rise && st_ff.rd
            && st_ff.bit_cnt == AMC_CNT_ADDR && rd_addr == AMC_ADDR_RESET)
            |=> st_ff.rd_data == 8'h00)
        else $error("reset register read not zero");

    // readback bit appears on sdo after a falling edge
    sdo_bit_a: assert property (
        rd_bit_s |=> sdo_oe_n == $past(st_ff.rd_data[7]))
        else $error("readback bit wrong on sdo");

    // edges beyond the sixteenth change nothing
    edge_limit_a: assert property (
        (!cs_s && st_ff.phase == PH_DONE) |=> st_ff.bit_cnt == AMC_CNT_FULL
                                              && $stable(st_ff.shift))
        else $error("edge taken after the sixteenth");

    // chip select high ends the transfer and releases sdo
    cs_end_a: assert property (
        cs_s |=> st_ff.phase == PH_IDLE && st_ff.bit_cnt == 5'h00 && sdo_oe_n)
        else $error("transfer not ended by chip select");

    // termination doubles the current of code 000
    cur_double_a: assert property (
        (st_ff.outm[AMC_TERM_BIT] && st_ff.outm[AMC_CUR_LSB+:3] == 3'h0) [*2]
            |-> lvds_current_units == {AMC_CUR_3P5[6:0], 1'b0})
        else $error("termination did not double current");

    // lowest current code without termination
    cur_base_a: assert property (
        (!st_ff.outm[AMC_TERM_BIT] && st_ff.outm[AMC_CUR_LSB+:3] == 3'h7) [*2]
            |-> lvds_current_units == AMC_CUR_1P75)
        else $error("driver current code wrong");

endmodule

/* File: amc_pkg.sv */
// Purpose: shared constants and types of the converter mode control register bank
// Assumes: 16-bit serial words, 7-bit address, 8-bit data
// Notes:   field positions and masks follow the bank layout; current figures in 50 uA units
package amc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // serial word layout
    localparam int unsigned AMC_WORD_BITS = 16;
    localparam int unsigned AMC_SYNC_W    = 3;
    localparam logic [4:0]  AMC_CNT_ADDR  = 5'h07; // edge that carries the last address bit
    localparam logic [4:0]  AMC_CNT_LAST  = 5'h0F; // edge that carries the last data bit
    localparam logic [4:0]  AMC_CNT_FULL  = 5'h10; // edges taken per transfer
    // synchroniser reset value, order {sdi, sck, cs_n}: chip select idles high
    localparam logic [2:0]  AMC_SYNC_RST  = 3'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [6:0] AMC_ADDR_RESET  = 7'h00;
    localparam logic [6:0] AMC_ADDR_CONV   = 7'h01;
    localparam logic [6:0] AMC_ADDR_UNUSED = 7'h02;
    localparam logic [6:0] AMC_ADDR_CLK    = 7'h03;
    localparam logic [6:0] AMC_ADDR_OUTM   = 7'h04;

    // reset value and writable-bit masks
    localparam logic [7:0] AMC_RESET_VAL = 8'h00;
    localparam logic [7:0] AMC_CONV_MASK = 8'h0E;
    localparam logic [7:0] AMC_CLK_MASK  = 8'h3F;
    localparam logic [7:0] AMC_OUTM_MASK = 8'h7D;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned AMC_SRST_BIT   = 7;
    localparam int unsigned AMC_GAIN_BIT   = 3;
    localparam int unsigned AMC_DITHER_BIT = 2;
    localparam int unsigned AMC_PDN_BIT    = 1;
    localparam int unsigned AMC_ETERM_BIT  = 5;
    localparam int unsigned AMC_KALIVE_BIT = 4;
    localparam int unsigned AMC_CINV_BIT   = 3;
    localparam int unsigned AMC_PHASE_LSB  = 1;
    localparam int unsigned AMC_STAB_BIT   = 0;
    localparam int unsigned AMC_CUR_LSB    = 4;
    localparam int unsigned AMC_TERM_BIT   = 3;
    localparam int unsigned AMC_OUTDIS_BIT = 2;
    localparam int unsigned AMC_FMT_BIT    = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // driver current in 50 uA units
    typedef logic [7:0] amc_cur_t;
    localparam amc_cur_t AMC_CUR_3P5  = 8'h46;
    localparam amc_cur_t AMC_CUR_4P0  = 8'h50;
    localparam amc_cur_t AMC_CUR_4P5  = 8'h5A;
    localparam amc_cur_t AMC_CUR_NONE = 8'h00;
    localparam amc_cur_t AMC_CUR_3P0  = 8'h3C;
    localparam amc_cur_t AMC_CUR_2P5  = 8'h32;
    localparam amc_cur_t AMC_CUR_2P1  = 8'h2A;
    localparam amc_cur_t AMC_CUR_1P75 = 8'h23;

    // serial transfer phases
    typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA, PH_DONE} amc_phase_e;

endpackage

/* File: amc_sync.sv */
// Purpose: two-stage synchroniser for the serial port pins
// Assumes: pins are asynchronous to core_clk
// Notes:   first stage feeds the second stage only
`timescale 1ns/1ps
module amc_sync (
    input  wire logic                           core_clk,
    input  wire logic                           rstn,
    input  wire logic [amc_pkg::AMC_SYNC_W-1:0] async_in,
    output logic      [amc_pkg::AMC_SYNC_W-1:0] sync_out
);
    import amc_pkg::*;

    typedef struct packed {
        logic [AMC_SYNC_W-1:0] stage1;
        logic [AMC_SYNC_W-1:0] stage2;
    } amc_sync_s;

    amc_sync_s st_ff;
    amc_sync_s nxt_st;

    ////////////////////////////////////////////////////////////////////////////////
    // next state: shift each pin through both stages
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.stage1 = async_in;
        nxt_st.stage2 = st_ff.stage1;
    end

    // state register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{stage1: AMC_SYNC_RST, stage2: AMC_SYNC_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stage2;

endmodule

/* File: amc_host.sv */
// Purpose: host model driving the three-wire serial port
// Assumes: serial clock of 125 ns period, free of the core clock
// Notes:   sdo is read on the line resolved with its pull-up
`timescale 1ns/1ps
module amc_host (
    output logic      cs_n,
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo
);
    localparam realtime HALF = 62.5;

    // serial lines idle with chip select high and clock still
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        sdi  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one word msb first; fewer than 16 edges abort, more send surplus edges
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                        input int nbits, output logic [7:0] rdat);
        logic [15:0] word;
        word = {rd, a, wd};
        rdat = 8'h00;
        cs_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi <= (i < 16) ? word[15 - i] : ~sdi;
            #HALF;
            sck <= 1'b1;
            if (i >= 8 && i < 16) rdat[15 - i] = sdo;
            #HALF;
            sck <= 1'b0;
        end
        #HALF;
        cs_n <= 1'b1;
        sdi  <= ~sdi; // deselected line shows no stale value
        #(2 * HALF);
    endtask
endmodule

/* File: tb_top.sv */
// Purpose: self-checking bench of the mode control register bank
// Assumes: host model on the serial port, sdo pulled up
// Notes:   random settings from xorshift seeded 52, corner cases among them
`timescale 1ns/1ps
module tb_top;
    import amc_pkg::*;
    logic       core_clk;
    logic       rstn;
    wire        cs_n, sck, sdi, sdo;
    logic       sdo_o, sdo_oe_n, transfer_active, gain, dither, pdn, eterm, keepalive, cinv;
    logic       term, out_dis, fmt, stab;
    logic       act_seen = 1'b0;
    logic [1:0] phase;
    logic [2:0] cur_sel;
    amc_cur_t   cur;
    logic [7:0] conv_m, clk_m, outm_m;
    logic [31:0] seed = 32'h0000_0034;
    int         failures = 0;
    int         num_checks = 0;
    amc_cur_t   cur_tab [8] = '{AMC_CUR_3P5, AMC_CUR_4P0, AMC_CUR_4P5, AMC_CUR_NONE,
                                AMC_CUR_3P0, AMC_CUR_2P5, AMC_CUR_2P1, AMC_CUR_1P75};

    ////////////////////////////////////////////////////////////////////////////////
    // clock, pull-up on sdo, design and host
    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;
    assign sdo = sdo_oe_n ? 1'b1 : sdo_o;

    // sticky flag: a transfer was reported at least once
    always @(posedge core_clk) begin
        if (transfer_active) begin
            act_seen <= 1'b1;
        end
    end

    amc_mode_regs DUT (
        .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .transfer_active(transfer_active),
        .front_end_gain_select(gain), .dither_disable(dither), .power_down_request(pdn),
        .encode_term_en(eterm), .keepalive_osc_disable(keepalive), .out_clock_invert(cinv),
        .out_clock_phase_delay(phase), .duty_cycle_stabilizer_en(stab),
        .driver_current_select(cur_sel), .internal_termination_en(term),
        .output_disable(out_dis), .output_format_cmos(fmt), .lvds_current_units(cur)
    );
    amc_host host (.cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo));

    ////////////////////////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] exp_rd(input logic [6:0] a);
        case (a)
            AMC_ADDR_CONV: return conv_m;
            AMC_ADDR_CLK:  return clk_m;
            AMC_ADDR_OUTM: return outm_m;
            default:       return 8'h00;
        endcase
    endfunction

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_outs();
        chk("gain", conv_m[3], gain);
        chk("dither", conv_m[2], dither);
        chk("pdn", conv_m[1], pdn);
        chk("eterm", clk_m[5], eterm);
        chk("keepalive", clk_m[4], keepalive);
        chk("cinv", clk_m[3], cinv);
        chk("phase", clk_m[2:1], phase);
        chk("stabilizer", clk_m[0], stab);
        chk("cur_sel", outm_m[6:4], cur_sel);
        chk("term", outm_m[3], term);
        chk("cur", outm_m[3] ? 8'(cur_tab[outm_m[6:4]] << 1) : cur_tab[outm_m[6:4]], cur);
        chk("out_disable", outm_m[2], out_dis);
        chk("fmt", outm_m[0], fmt);
        chk("idle", 8'h01, {transfer_active, sdo_oe_n});
    endtask

    // write a word and track the register contents
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        host.xfer(1'b0, a, d, 16, unused);
        if (a == AMC_ADDR_RESET && d[7]) {conv_m, clk_m, outm_m} = '0;
        if (a == AMC_ADDR_CONV) conv_m = d & 8'h0E;
        if (a == AMC_ADDR_CLK) clk_m = d & 8'h3F;
        if (a == AMC_ADDR_OUTM) outm_m = d & 8'h7D;
    endtask

    // read back with random bits on sdi, which must not be stored
    task automatic rd_chk(input logic [6:0] a);
        logic [7:0] got;
        seed = xorshift(seed);
        host.xfer(1'b1, a, seed[7:0], 16, got);
        chk("readback", exp_rd(a), got);
        check_outs();
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog against a hang
    initial begin
        repeat (50000) @(posedge core_clk);
        failures++;
        complete_run();
    end

    // main sequence
    initial begin
        logic [6:0] a;
        logic [7:0] d;
        logic [7:0] got;
        rstn = 1'b0;
        {conv_m, clk_m, outm_m} = '0;
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        #16.25; // keeps host edges off the core clock edges
        check_outs();
        wr(AMC_ADDR_RESET, 8'h80);
        rd_chk(AMC_ADDR_RESET);
        chk("active", 8'h01, {7'h00, act_seen});
        for (int i = 0; i < 32; i++) begin
            seed = xorshift(seed);
            a = (i < 16) ? AMC_ADDR_OUTM : 7'(seed[10:8] % 3'd6);
            d = seed[7:0];
            if (i < 16) d[6:3] = 4'(i);
            if (a == AMC_ADDR_CLK && d[2:1] != 2'h0) d[0] = 1'b1;
            wr(a, d);
            check_outs();
            rd_chk(a);
        end
        wr(AMC_ADDR_CONV, 8'hFF);
        wr(AMC_ADDR_CLK, 8'hFF);
        wr(AMC_ADDR_OUTM, 8'hFF);
        rd_chk(AMC_ADDR_CONV);
        host.xfer(1'b0, AMC_ADDR_CONV, 8'h00, 10, got);
        check_outs();
        host.xfer(1'b0, AMC_ADDR_CLK, 8'h30, 20, got);
        clk_m = 8'h30;
        check_outs();
        wr(AMC_ADDR_UNUSED, 8'hFF);
        rd_chk(AMC_ADDR_UNUSED);
        wr(7'h7F, 8'hFF);
        rd_chk(7'h7F);
        wr(AMC_ADDR_RESET, 8'hFF);
        check_outs();
        rd_chk(AMC_ADDR_RESET);
        complete_run();
    end
endmodule
